// file: pkg/posm_consts.vh
// Constants for the process overload and stall monitor.
// Assumes a 20 MHz pclk and 32-bit APB data.
`ifndef POSM_CONSTS_VH
`define POSM_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define POSM_OFS_OVL_TIME 12'h000
`define POSM_OFS_OVL_THR 12'h004
`define POSM_OFS_OVL_CFG 12'h008
`define POSM_OFS_STALL_TIME 12'h00C
`define POSM_OFS_STALL_LVL 12'h010
`define POSM_OFS_STATUS 12'h014

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POSM_THR_PCT_LSB 0
`define POSM_THR_PCT_MSB 7
`define POSM_HYST_LSB 16
`define POSM_HYST_MSB 27
`define POSM_REACT_LSB 0
`define POSM_REACT_MSB 1
`define POSM_RDLY_LSB 4
`define POSM_RDLY_MSB 6
`define POSM_STALL_EN_BIT 8
`define POSM_SCUR_LSB 0
`define POSM_SCUR_MSB 11
`define POSM_SFRQ_LSB 16
`define POSM_SFRQ_MSB 27
`define POSM_ST_OVL_BIT 0
`define POSM_ST_STALL_BIT 1
`define POSM_ST_INHIB_BIT 2

// ----------------------------------------
// Reset values (times in 0.1 s, freq in 0.1 Hz, current in 0.1 %)
// ----------------------------------------
`define POSM_RST_OVL_TIME 11'h000
`define POSM_RST_THR_PCT 8'h6E
`define POSM_RST_HYST 12'h003
`define POSM_RST_REACT 2'h1
`define POSM_RST_RDLY 3'h0
`define POSM_RST_STALL_TIME 11'h258
`define POSM_RST_SCUR 12'h5DC
`define POSM_RST_SFRQ 12'h014

// ----------------------------------------
// Limits and scaling
// ----------------------------------------
`define POSM_MAX_OVL_TIME 11'h3E8
`define POSM_MAX_STALL_TIME 11'h7D0
`define POSM_MAX_RDLY 3'h6
`define POSM_PCT_TO_DECI 4'hA
`define POSM_TICKS_PER_MIN 10'h258

// ----------------------------------------
// Reactions
// ----------------------------------------
`define POSM_REACT_IGNORE 2'h0
`define POSM_REACT_FREEWHEEL 2'h1
`define POSM_REACT_RAMP 2'h2
`define POSM_REACT_FAST 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define POSM_CLK_HZ 20000000
`define POSM_TICK_MS 100
`endif

// file: logic/posm_top.v
// Process overload and stall monitor with APB register access.
// Assumes motor-core inputs arrive on pclk and need no synchroniser.
//
// Operation
// - Overload flagged after condition held detection time
// - Current limit while ramping is overload
// - Steady state with current above threshold
// - Steady state when frequency error below hysteresis
// - Current limitation always counts as overload
// - Zero detection time disables overload monitor
// - Overload threshold in percent, default 110
// - Hysteresis default 0.3 Hz
// - Selected stop reaction, freewheel by default
// - Restart held off for delay, 0-6 minutes
// - Stall: low frequency, high current, too long
// - Stall raises motor stall error
// - Stall monitor enable, disabled after reset
// - Stall time up to 200 s, default 60
// - Stall current percent, default 150.0
// - Stall frequency default 2.0 Hz
`timescale 1ns/1ps
`include "posm_consts.vh"

module posm_top #(
   parameter TICK_CYCLES = (`POSM_CLK_HZ / 1000) * `POSM_TICK_MS,
   parameter FW = 12,
   parameter CW = 16
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   input wire [FW-1:0] ref_freq,
   input wire [FW-1:0] motor_freq,
   input wire [FW-1:0] out_freq,
   input wire [CW-1:0] motor_current,
   input wire cur_limit,
   input wire ramping,
   output reg ovl_detect,
   output reg stop_freewheel,
   output reg stop_ramp,
   output reg stop_fast,
   output reg restart_inhibit,
   output reg stall_error
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [10:0] ovl_time_reg;
reg [7:0] thr_pct_reg;
reg [11:0] hyst_reg;
reg [1:0] react_reg;
reg [2:0] rdly_reg;
reg stall_en_reg;
reg [10:0] stall_time_reg;
reg [11:0] scur_reg;
reg [11:0] sfrq_reg;
reg [31:0] tick_cnt_reg;
reg tick_reg;
reg [10:0] ovl_cnt_reg;
reg [10:0] stall_cnt_reg;
reg [11:0] rdly_cnt_reg;
reg ovl_hit_reg;

wire wr_en = psel & penable & pwrite & ce;
// Read capture frozen with the rest of the state while ce is low
wire setup = psel & ~penable & ce;
wire clr_ovl = wr_en && (paddr == `POSM_OFS_STATUS) && pwdata[`POSM_ST_OVL_BIT];
wire clr_stall = wr_en && (paddr == `POSM_OFS_STATUS) && pwdata[`POSM_ST_STALL_BIT];

assign pready = 1'b1;

// ----------------------------------------
// Steady state and conditions
// ----------------------------------------
wire [FW-1:0] freq_err = (ref_freq > motor_freq) ? (ref_freq - motor_freq) : (motor_freq - ref_freq);
wire steady = (freq_err < hyst_reg);
wire [CW-1:0] thr_deci = {{(CW-8){1'b0}}, thr_pct_reg} * {{(CW-4){1'b0}}, `POSM_PCT_TO_DECI};
wire ovl_enabled = (ovl_time_reg != `POSM_RST_OVL_TIME);
// Current limitation counts in any phase, ramping included
wire ovl_cond = ovl_enabled & (cur_limit | (ramping & cur_limit) |
   (steady & (motor_current > thr_deci)));
wire stall_cond = stall_en_reg & (out_freq < sfrq_reg) & (motor_current > scur_reg);
wire ovl_fire = ovl_cond & (ovl_cnt_reg >= ovl_time_reg) & ~ovl_hit_reg;
wire stall_fire = stall_cond & (stall_cnt_reg > stall_time_reg);
wire [11:0] rdly_load = {9'h000, rdly_reg} * {2'h0, `POSM_TICKS_PER_MIN};

// ----------------------------------------
// Timebase
// ----------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
   end
   else if (ce)
   begin
      if (tick_cnt_reg == TICK_CYCLES - 1)
      begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg <= 1'b1;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
         tick_reg <= 1'b0;
      end
   end
end

// ----------------------------------------
// Persistence timers
// ----------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      ovl_cnt_reg <= 11'h000;
      stall_cnt_reg <= 11'h000;
      ovl_hit_reg <= 1'b0;
   end
   else if (ce)
   begin
      if (!ovl_cond)
      begin
         ovl_cnt_reg <= 11'h000;
         ovl_hit_reg <= 1'b0;
      end
      else
      begin
         if (tick_reg && ovl_cnt_reg != 11'h7FF)
            ovl_cnt_reg <= ovl_cnt_reg + 11'h001;
         if (ovl_fire)
            ovl_hit_reg <= 1'b1;
      end
      if (!stall_cond)
         stall_cnt_reg <= 11'h000;
      else if (tick_reg && stall_cnt_reg != 11'h7FF)
         stall_cnt_reg <= stall_cnt_reg + 11'h001;
   end
end

// ----------------------------------------
// Detection, reaction, restart hold-off
// ----------------------------------------
// Set wins over a same-cycle software clear
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      ovl_detect <= 1'b0;
      stall_error <= 1'b0;
      stop_freewheel <= 1'b0;
      stop_ramp <= 1'b0;
      stop_fast <= 1'b0;
      rdly_cnt_reg <= 12'h000;
      restart_inhibit <= 1'b0;
   end
   else if (ce)
   begin
      if (ovl_fire)
      begin
         ovl_detect <= 1'b1;
         stop_freewheel <= (react_reg == `POSM_REACT_FREEWHEEL);
         stop_ramp <= (react_reg == `POSM_REACT_RAMP);
         stop_fast <= (react_reg == `POSM_REACT_FAST);
      end
      else if (clr_ovl)
      begin
         ovl_detect <= 1'b0;
         stop_freewheel <= 1'b0;
         stop_ramp <= 1'b0;
         stop_fast <= 1'b0;
      end
      if (stall_fire)
         stall_error <= 1'b1;
      else if (clr_stall)
         stall_error <= 1'b0;
      if (ovl_fire && react_reg != `POSM_REACT_IGNORE)
      begin
         rdly_cnt_reg <= rdly_load;
         restart_inhibit <= (rdly_load != 12'h000);
      end
      else if (tick_reg && rdly_cnt_reg != 12'h000)
      begin
         rdly_cnt_reg <= rdly_cnt_reg - 12'h001;
         restart_inhibit <= (rdly_cnt_reg != 12'h001);
      end
   end
end

// ----------------------------------------
// APB writes
// ----------------------------------------
// Out-of-range values saturate; hold-off is timed from detection, independent of the software fault reset
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      ovl_time_reg <= `POSM_RST_OVL_TIME;
      thr_pct_reg <= `POSM_RST_THR_PCT;
      hyst_reg <= `POSM_RST_HYST;
      react_reg <= `POSM_RST_REACT;
      rdly_reg <= `POSM_RST_RDLY;
      stall_en_reg <= 1'b0;
      stall_time_reg <= `POSM_RST_STALL_TIME;
      scur_reg <= `POSM_RST_SCUR;
      sfrq_reg <= `POSM_RST_SFRQ;
   end
   else if (wr_en)
   begin
      case (paddr)
         `POSM_OFS_OVL_TIME:
         begin
            if (pwdata[10:0] > `POSM_MAX_OVL_TIME)
               ovl_time_reg <= `POSM_MAX_OVL_TIME;
            else
               ovl_time_reg <= pwdata[10:0];
         end
         `POSM_OFS_OVL_THR:
         begin
            thr_pct_reg <= pwdata[`POSM_THR_PCT_MSB:`POSM_THR_PCT_LSB];
            hyst_reg <= pwdata[`POSM_HYST_MSB:`POSM_HYST_LSB];
         end
         `POSM_OFS_OVL_CFG:
         begin
            react_reg <= pwdata[`POSM_REACT_MSB:`POSM_REACT_LSB];
            if (pwdata[`POSM_RDLY_MSB:`POSM_RDLY_LSB] > `POSM_MAX_RDLY)
               rdly_reg <= `POSM_MAX_RDLY;
            else
               rdly_reg <= pwdata[`POSM_RDLY_MSB:`POSM_RDLY_LSB];
            stall_en_reg <= pwdata[`POSM_STALL_EN_BIT];
         end
         `POSM_OFS_STALL_TIME:
         begin
            if (pwdata[10:0] > `POSM_MAX_STALL_TIME)
               stall_time_reg <= `POSM_MAX_STALL_TIME;
            else
               stall_time_reg <= pwdata[10:0];
         end
         `POSM_OFS_STALL_LVL:
         begin
            scur_reg <= pwdata[`POSM_SCUR_MSB:`POSM_SCUR_LSB];
            sfrq_reg <= pwdata[`POSM_SFRQ_MSB:`POSM_SFRQ_LSB];
         end
         default:
         begin
            ovl_time_reg <= ovl_time_reg;
         end
      endcase
   end
end

// ----------------------------------------
// APB reads, captured in the setup cycle
// ----------------------------------------
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
   end
   else if (setup)
   begin
      pslverr <= 1'b0;
      case (paddr)
         `POSM_OFS_OVL_TIME: prdata <= {21'h000000, ovl_time_reg};
         `POSM_OFS_OVL_THR: prdata <= {4'h0, hyst_reg, 8'h00, thr_pct_reg};
         `POSM_OFS_OVL_CFG: prdata <= {23'h000000, stall_en_reg, 1'b0, rdly_reg, 2'h0, react_reg};
         `POSM_OFS_STALL_TIME: prdata <= {21'h000000, stall_time_reg};
         `POSM_OFS_STALL_LVL: prdata <= {4'h0, sfrq_reg, 4'h0, scur_reg};
         `POSM_OFS_STATUS: prdata <= {29'h00000000, restart_inhibit, stall_error, ovl_detect};
         default:
         begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
         end
      endcase
   end
end

endmodule

// file: bench/posm_core_model.sv
// Motor-core stand-in driving measured values into the monitor.
// Assumes mode and jit come from the bench on pclk.
`timescale 1ns/1ps
module posm_core_model (
   input wire pclk,
   input wire [2:0] mode,
   input wire [7:0] jit,
   output reg [11:0] ref_freq,
   output reg [11:0] motor_freq,
   output reg [11:0] out_freq,
   output reg [15:0] motor_current,
   output reg cur_limit,
   output reg ramping
);
   // ---------------
   // Operating points
   // ---------------
   always @(posedge pclk)
   begin
      ref_freq <= 12'h1F4;
      cur_limit <= mode == 3'h1 || mode == 3'h5;
      ramping <= mode == 3'h1;
      // Mode 4 sits exactly on the band edge, so not steady
      motor_freq <= mode == 3'h2 ? 12'h1F5 : mode == 3'h4 ? 12'h1F7 : 12'h12C + jit;
      out_freq <= mode == 3'h3 ? 12'h013 - jit[3:0] : 12'h12C;
      // Steady current kept under a 140 % limit
      motor_current <= mode == 3'h2 ? 16'h44D + jit : mode == 3'h3 ? 16'h5DD + jit :
         mode == 3'h4 ? 16'h514 : 16'h1F4 + jit;
   end
endmodule

// file: bench/posm_checker_assertions.sv
// Port assertions for the overload and stall monitor.
// Assumes binding onto posm_top.
`timescale 1ns/1ps
module posm_checker (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire ovl_detect,
   input wire stop_freewheel,
   input wire stop_ramp,
   input wire stop_fast,
   input wire restart_inhibit,
   input wire stall_error
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire clr_w = psel && penable && pwrite && ce && paddr == 12'h014;
   wire [5:0] outs = {stall_error, restart_inhibit, stop_fast, stop_ramp, stop_freewheel, ovl_detect};
   sequence setup_s;
      psel && !penable && ce;
   endsequence
   sequence bad_s;
      setup_s ##0 (paddr > 12'h014 || paddr[1:0] != 2'h0);
   endsequence
   ready_high_a: assert property (pready) else $error("pready low");
   bad_addr_a: assert property (bad_s |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
   good_addr_a: assert property (setup_s ##0 !(paddr > 12'h014 || paddr[1:0] != 2'h0) |=> !pslverr)
      else $error("mapped refused");
   stop_one_a: assert property ($onehot0({stop_fast, stop_ramp, stop_freewheel})) else $error("two stops");
   stop_cause_a: assert property ((stop_freewheel || stop_ramp || stop_fast) |-> ovl_detect)
      else $error("stop without overload");
   ovl_hold_a: assert property (ovl_detect && !(clr_w && pwdata[0]) |=> ovl_detect) else $error("ovl lost");
   stall_hold_a: assert property (stall_error && !(clr_w && pwdata[1]) |=> stall_error)
      else $error("stall lost");
   ce_freeze_a: assert property (!ce |=> $stable(outs)) else $error("moved while frozen");
   inhibit_cause_a: assert property ($rose(restart_inhibit) |-> ovl_detect) else $error("stray inhibit");
endmodule
bind posm_top posm_checker posm_checker_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .ovl_detect(ovl_detect), .stop_freewheel(stop_freewheel), .stop_ramp(stop_ramp),
   .stop_fast(stop_fast), .restart_inhibit(restart_inhibit), .stall_error(stall_error));

// file: bench/process_overload_stall_monitor_test.sv
// Self-checking bench for posm_top with a motor-core model.
// Assumes a short tick of 10 pclk cycles per 0.1 s.
`timescale 1ns/1ps
module process_overload_stall_monitor_test;
   reg pclk, presetn, ce, psel, penable, pwrite;
   reg [11:0] paddr;
   reg [31:0] pwdata;
   reg [2:0] mode;
   reg [7:0] jit;
   integer seed, mismatches, total_checks, r;
   wire pready, pslverr, cl, rp, ovl_detect, stop_freewheel, stop_ramp, stop_fast, restart_inhibit, stall_error;
   wire [31:0] prdata;
   wire [11:0] rf, mf, of;
   wire [15:0] mc;
   wire [5:0] outs = {stall_error, restart_inhibit, stop_fast, stop_ramp, stop_freewheel, ovl_detect};
   reg [31:0] rv [0:5];
   posm_top #(.TICK_CYCLES(10)) posm_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .ref_freq(rf), .motor_freq(mf), .out_freq(of), .motor_current(mc), .cur_limit(cl),
      .ramping(rp), .ovl_detect(ovl_detect), .stop_freewheel(stop_freewheel), .stop_ramp(stop_ramp),
      .stop_fast(stop_fast), .restart_inhibit(restart_inhibit), .stall_error(stall_error));
   posm_core_model posm_core_model_inst (.pclk(pclk), .mode(mode), .jit(jit), .ref_freq(rf), .motor_freq(mf),
      .out_freq(of), .motor_current(mc), .cur_limit(cl), .ramping(rp));
   initial
   begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) jit <= $random(seed);
   function [2:0] exp_stop(input [1:0] rc);
      exp_stop = (rc == 2'h0) ? 3'h0 : 3'h1 << (rc - 2'h1);
   endfunction
   task end_of_test;
   begin
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   task chk(input [31:0] s, input [31:0] e);
   begin
      total_checks = total_checks + 1;
      if (s !== e)
      begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   end
   endtask
   // Holds the request until pready is seen high at an edge
   task apb(input [11:0] a, input w, input [31:0] d, input [31:0] e, input ee);
      integer i;
   begin
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 20)
      begin
         @(posedge pclk);
         i = i + 1;
      end
      if (!w)
         chk(prdata, e);
      chk({31'h0, pslverr}, {31'h0, ee});
      psel <= 1'b0; penable <= 1'b0;
      if (i >= 20)
      begin
         mismatches = mismatches + 1;
         end_of_test;
      end
   end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge pclk);
   endtask
   task waitv(input integer k, input v, input integer n);
      integer i;
   begin
      i = 0;
      while (outs[k] !== v && i < n)
      begin
         @(negedge pclk);
         i = i + 1;
      end
      chk({31'h0, outs[k]}, {31'h0, v});
      if (i >= n)
         end_of_test;
   end
   endtask
   initial
   begin
      seed = 32'h84ad; mismatches = 0; total_checks = 0;
      presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; mode = 0;
      rv[0] = 32'h0; rv[1] = 32'h0003006E; rv[2] = 32'h1; rv[3] = 32'h258; rv[4] = 32'h001405DC; rv[5] = 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (r = 0; r < 6; r = r + 1)
         apb(r * 4, 0, 0, rv[r], 0);
      apb(12'h018, 0, 0, 0, 1);
      mode <= 3'h1;
      cyc(40);
      chk(outs, 0);
      $display("test done: reset and disabled");
      mode <= 3'h0;
      apb(0, 1, 3, 0, 0);
      for (r = 0; r < 4; r = r + 1)
      begin
         apb(8, 1, r, 0, 0);
         mode <= (r == 1) ? 3'h5 : (r == 2) ? 3'h2 : 3'h1;
         cyc(20);
         chk(outs[0], 0);
         waitv(0, 1, 40);
         chk(outs[3:1], exp_stop(r));
         mode <= 3'h0;
         apb(12'h014, 1, 1, 0, 0);
         cyc(1);
         chk(outs[0], 0);
      end
      $display("test done: reactions");
      mode <= 3'h1;
      cyc(15);
      mode <= 3'h0;
      cyc(3);
      mode <= 3'h1;
      cyc(15);
      chk(outs[0], 0);
      mode <= 3'h4;
      cyc(40);
      chk(outs[0], 0);
      mode <= 3'h3;
      cyc(40);
      chk(outs[5], 0);
      $display("test done: dropout and boundary");
      mode <= 3'h0;
      apb(0, 1, 0, 0, 0);
      apb(12'h00C, 1, 2, 0, 0);
      apb(8, 1, 32'h101, 0, 0);
      mode <= 3'h3;
      cyc(15);
      chk(outs[5], 0);
      waitv(5, 1, 40);
      @(posedge pclk);
      ce <= 1'b0;
      repeat (8) @(posedge pclk);
      ce <= 1'b1;
      chk(outs[5], 1);
      mode <= 3'h0;
      apb(12'h014, 1, 2, 0, 0);
      cyc(1);
      chk(outs[5], 0);
      apb(12'h00C, 1, 32'h7FF, 0, 0);
      apb(12'h00C, 0, 0, 32'h7D0, 0);
      apb(0, 1, 32'h7FF, 0, 0);
      apb(0, 0, 0, 32'h3E8, 0);
      apb(8, 1, 32'h70, 0, 0);
      apb(8, 0, 0, 32'h60, 0);
      $display("test done: stall and limits");
      apb(8, 1, 32'h11, 0, 0);
      apb(0, 1, 1, 0, 0);
      mode <= 3'h1;
      waitv(0, 1, 40);
      chk(outs[4], 1);
      mode <= 3'h0;
      apb(12'h014, 1, 1, 0, 0);
      cyc(1);
      cyc(5900);
      chk(outs[4], 1);
      waitv(4, 0, 300);
      $display("test done: restart delay");
      end_of_test;
   end
endmodule
